// [tap_pkg.sv]
// Constants and types shared by the boundary-scan test port.
// Assumes a single package compiled ahead of the design file.
package tap_pkg;
  localparam int NUM_IO = 68;
  localparam int NUM_IN = 4;
  localparam int NUM_PIN = 72;
  localparam int NUM_MC = 64;
  localparam int CELL_CAP = 3;
  localparam int BSR_LEN = 280;
  localparam int CAP_IN = 0;
  localparam int CAP_OUT = 1;
  localparam int CAP_OE = 2;
  localparam int MC_BASE = 216;
  localparam int IR_W = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_HIGHZ = 4'h3;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // Arbitrary identity value, low bit set as the scan standard wants
  localparam logic [31:0] IDCODE_VAL = 32'h1234_5679;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_e;
endpackage

// [jtag_boundary_scan_tap.sv]
// Boundary-scan test access port with its cell chain and pin steering.
// Assumes tck from the test controller, core_clk for the pad side.
`timescale 1ns/100ps
`default_nettype none

module jtag_boundary_scan_tap (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic jtag_en,
  output logic [2:0] user_in,
  input wire logic user_out,
  input wire logic user_oe,
  input wire logic [71:0] pin_in,
  output logic [71:0] core_in,
  input wire logic [67:0] core_out,
  input wire logic [67:0] core_oe,
  output logic [67:0] pad_out,
  output logic [67:0] pad_oe,
  input wire logic [63:0] mc_q
);

  function automatic logic is_bscan(input logic [3:0] op);
    is_bscan = (op == tap_pkg::OP_EXTEST) || (op == tap_pkg::OP_SAMPLE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Core-side hold request and reset crossing

  logic hold_tap;
  logic rst_m1, rst_tck;
  logic ack_m1, ack_c;

  always_ff @(posedge core_clk) begin
    if (rst || !jtag_en) begin
      hold_tap <= 1'b1;
    end else if (ack_c) begin
      hold_tap <= 1'b0;
    end
  end

  // Test clock side reset seen
  always_ff @(posedge core_clk) begin
    ack_m1 <= rst_tck;
    ack_c <= ack_m1;
  end

  always_ff @(posedge tck) begin
    rst_m1 <= hold_tap;
    rst_tck <= rst_m1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Live signals into the test clock domain

  logic [71:0] pin_m1, pin_t;
  logic [67:0] co_m1, co_t, coe_m1, coe_t;
  logic [63:0] mc_m1, mc_t;

  always_ff @(posedge tck) begin
    pin_m1 <= pin_in;
    pin_t <= pin_m1;
    co_m1 <= core_out;
    co_t <= co_m1;
    coe_m1 <= core_oe;
    coe_t <= coe_m1;
    mc_m1 <= mc_q;
    mc_t <= mc_m1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller state machine

  tap_pkg::tap_state_e state, next_state;

  always_comb begin
    next_state = state;
    case (state)
      tap_pkg::TLR: next_state = tms ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: next_state = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: next_state = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: next_state = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: next_state = tms ? tap_pkg::UPD_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: next_state = tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: next_state = tms ? tap_pkg::UPD_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPD_DR: next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: next_state = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: next_state = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: next_state = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: next_state = tms ? tap_pkg::UPD_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: next_state = tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: next_state = tms ? tap_pkg::UPD_IR : tap_pkg::SHIFT_IR;
      tap_pkg::UPD_IR: next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default: next_state = tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      state <= tap_pkg::TLR;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction register

  logic [3:0] ir_sh, ir;
  logic ext_t, hz_t;

  always_ff @(posedge tck) begin
    if (rst_tck || state == tap_pkg::TLR) begin
      ir_sh <= tap_pkg::IR_CAPTURE;
      ir <= tap_pkg::OP_IDCODE;
      ext_t <= 1'b0;
      hz_t <= 1'b0;
    end else if (state == tap_pkg::CAP_IR) begin
      ir_sh <= tap_pkg::IR_CAPTURE;
    end else if (state == tap_pkg::SHIFT_IR) begin
      ir_sh <= {tdi, ir_sh[3:1]};
    end else if (state == tap_pkg::UPD_IR) begin
      ir <= ir_sh;
      ext_t <= (ir_sh == tap_pkg::OP_EXTEST);
      hz_t <= (ir_sh == tap_pkg::OP_HIGHZ);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data registers and boundary chain

  logic bypass_r;
  logic [31:0] id_sh;
  logic [279:0] bsr, cap;
  logic [67:0] upd_out, upd_oe;
  logic dr_bit;

  always_comb begin
    cap = '0;
    for (int i = 0; i < tap_pkg::NUM_PIN; i++) begin
      cap[i * tap_pkg::CELL_CAP + tap_pkg::CAP_IN] = pin_t[i];
      if (i < tap_pkg::NUM_IO) begin
        cap[i * tap_pkg::CELL_CAP + tap_pkg::CAP_OUT] = co_t[i];
        cap[i * tap_pkg::CELL_CAP + tap_pkg::CAP_OE] = coe_t[i];
      end
    end
    for (int j = 0; j < tap_pkg::NUM_MC; j++) begin
      cap[tap_pkg::MC_BASE + j] = mc_t[j];
    end
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      bypass_r <= 1'b0;
      id_sh <= tap_pkg::IDCODE_VAL;
      bsr <= '0;
    end else if (state == tap_pkg::CAP_DR) begin
      bypass_r <= 1'b0;
      id_sh <= tap_pkg::IDCODE_VAL;
      if (is_bscan(ir)) begin
        bsr <= cap;
      end
    end else if (state == tap_pkg::SHIFT_DR) begin
      bypass_r <= tdi;
      id_sh <= {tdi, id_sh[31:1]};
      if (is_bscan(ir)) begin
        bsr <= {tdi, bsr[279:1]};
      end
    end
  end

  // two update stages per I/O cell
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      upd_out <= '0;
      upd_oe <= '0;
    end else if (state == tap_pkg::UPD_DR && is_bscan(ir)) begin
      for (int i = 0; i < tap_pkg::NUM_IO; i++) begin
        upd_out[i] <= bsr[i * tap_pkg::CELL_CAP + tap_pkg::CAP_OUT];
        upd_oe[i] <= bsr[i * tap_pkg::CELL_CAP + tap_pkg::CAP_OE];
      end
    end
  end

  always_comb begin
    if (is_bscan(ir)) begin
      dr_bit = bsr[0];
    end else if (ir == tap_pkg::OP_IDCODE) begin
      dr_bit = id_sh[0];
    end else begin
      dr_bit = bypass_r;
    end
  end

  logic tdo_t, tdo_en_t;

  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo_t <= 1'b0;
      tdo_en_t <= 1'b0;
    end else begin
      tdo_t <= (state == tap_pkg::SHIFT_IR) ? ir_sh[0] : dr_bit;
      tdo_en_t <= (state == tap_pkg::SHIFT_IR) || (state == tap_pkg::SHIFT_DR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core-side crossings and pad steering

  logic ext_m1, ext_c, hz_m1, hz_c, tdo_m1, tdo_c, ten_m1, ten_c;
  logic [67:0] uo_m1, uo_c, ue_m1, ue_c;
  logic [71:0] pin_c1;
  logic [2:0] up_m1, up_c;

  always_ff @(posedge core_clk) begin
    ext_m1 <= ext_t;
    ext_c <= ext_m1;
    hz_m1 <= hz_t;
    hz_c <= hz_m1;
    tdo_m1 <= tdo_t;
    tdo_c <= tdo_m1;
    ten_m1 <= tdo_en_t;
    ten_c <= ten_m1;
    uo_m1 <= upd_out;
    uo_c <= uo_m1;
    ue_m1 <= upd_oe;
    ue_c <= ue_m1;
    pin_c1 <= pin_in;
    up_m1 <= {tdi, tms, tck};
    up_c <= up_m1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe <= '0;
      core_in <= '0;
    end else begin
      pad_out <= ext_c ? uo_c : core_out;
      pad_oe <= hz_c ? '0 : (ext_c ? ue_c : core_oe);
      core_in <= pin_c1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      user_in <= '0;
    end else begin
      tdo <= jtag_en ? tdo_c : user_out;
      tdo_oe <= jtag_en ? ten_c : user_oe;
      user_in <= jtag_en ? 3'h0 : up_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_tms_reset;
    @(posedge tck) disable iff (rst_tck) tms [*5] |=> state == tap_pkg::TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("tms reset failed");

  property p_por;
    @(posedge tck) rst_tck |=> state == tap_pkg::TLR && ir == tap_pkg::OP_IDCODE;
  endproperty
  a_por: assert property (p_por) else $error("power-up reset failed");

  property p_ir_capture;
    @(posedge tck) disable iff (rst_tck)
      state == tap_pkg::CAP_IR |=> ir_sh == tap_pkg::IR_CAPTURE;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("ir capture wrong");

  property p_bypass;
    @(posedge tck) disable iff (rst_tck)
      state == tap_pkg::SHIFT_DR && ir == tap_pkg::OP_BYPASS |=> dr_bit == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong");

  property p_shift;
    @(posedge tck) disable iff (rst_tck)
      state == tap_pkg::SHIFT_DR && is_bscan(ir) |=> bsr[279] == $past(tdi)
        && bsr[278] == $past(bsr[279]);
  endproperty
  a_shift: assert property (p_shift) else $error("chain shift wrong");

  property p_capture;
    @(posedge tck) disable iff (rst_tck)
      state == tap_pkg::CAP_DR && is_bscan(ir) |=> bsr[0] == $past(pin_t[0])
        && bsr[tap_pkg::MC_BASE] == $past(mc_t[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_update;
    @(posedge tck) disable iff (rst_tck)
      state == tap_pkg::UPD_DR && is_bscan(ir) |=> upd_out[0] == $past(bsr[1])
        && upd_oe[67] == $past(bsr[203]);
  endproperty
  a_update: assert property (p_update) else $error("update wrong");

  property p_hold;
    @(posedge tck) disable iff (rst_tck)
      state != tap_pkg::UPD_DR |=> $stable(upd_out);
  endproperty
  a_hold: assert property (p_hold) else $error("update changed outside strobe");

  property p_highz;
    @(posedge core_clk) disable iff (rst) hz_c |=> pad_oe == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("highz pads driven");

  property p_user_io;
    @(posedge core_clk) disable iff (rst)
      !jtag_en |=> tdo == $past(user_out) && tdo_oe == $past(user_oe);
  endproperty
  a_user_io: assert property (p_user_io) else $error("user pin path wrong");

endmodule

`default_nettype wire

// [scan_ctrl_model.sv]
// Behavioural test controller for the four-wire scan port.
// Assumes tck idles low between frames and tdo settles within 80 ns.
`timescale 1ns/100ps
`default_nettype none
module scan_ctrl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////
  // pins-only serial access
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    q = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask
  task automatic park(input logic m, input logic d);
    tms = m;
    tdi = d;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [279:0] din,
      output logic [279:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model drives tck, tms and tdi.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk, rst, jtag_en, user_out, user_oe, tck, tms, tdi, tdo, tdo_oe;
  logic [2:0] user_in;
  logic [71:0] pin_in, core_in;
  logic [67:0] core_out, core_oe, pad_out, pad_oe;
  logic [63:0] mc_q;
  logic [279:0] d, pre, exp_bsr;
  int errors, comparisons, cycles;
  wire tdo_pin;
  // Released pin reads as the inverse
  assign tdo_pin = tdo_oe ? tdo : ~tdo;
  ////////////////////////////////////////
  jtag_boundary_scan_tap DUT (.core_clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe, .jtag_en,
    .user_in, .user_out, .user_oe, .pin_in, .core_in, .core_out, .core_oe, .pad_out,
    .pad_oe, .mc_q);
  scan_ctrl_model ctrl (.tck, .tms, .tdi, .tdo(tdo_pin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic chk_scan(input logic [279:0] got, input logic [279:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_idcode();
    ctrl.reset_tap();
    ctrl.scan(1'b0, 32, '0, d);
    chk_scan(d[31:0], tap_pkg::IDCODE_VAL);
  endtask
  task automatic t_bypass(input logic [3:0] op);
    ctrl.scan(1'b1, 4, {276'h0, op}, d);
    chk_scan(d[3:0], tap_pkg::IR_CAPTURE);
    ctrl.scan(1'b0, 9, 280'h0A7, d);
    chk_scan(d[8:0], 9'h14E);
  endtask
  task automatic t_sample();
    exp_bsr = '0;
    for (int i = 0; i < 72; i++) begin
      exp_bsr[3 * i] = pin_in[i];
      if (i < 68) begin
        exp_bsr[3 * i + 1] = core_out[i];
        exp_bsr[3 * i + 2] = core_oe[i];
      end
    end
    for (int j = 0; j < 64; j++) exp_bsr[tap_pkg::MC_BASE + j] = mc_q[j];
    ctrl.scan(1'b1, 4, {276'h0, tap_pkg::OP_SAMPLE}, d);
    ctrl.scan(1'b0, 280, pre, d);
    chk_scan(d, exp_bsr);
    chk_pin(core_in, pin_in);
  endtask
  task automatic t_extest();
    ctrl.scan(1'b1, 4, {276'h0, tap_pkg::OP_EXTEST}, d);
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 68; i++) begin
      exp_bsr[i] = pre[3 * i + 1];
      exp_bsr[100 + i] = pre[3 * i + 2];
    end
    chk_pin(pad_out, exp_bsr[67:0]);
    chk_pin(pad_oe, exp_bsr[167:100]);
  endtask
  task automatic t_rerst();
    logic q;
    @(negedge core_clk);
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_pin(pad_oe, 68'h0);
    rst = 1'b0;
    repeat (5) ctrl.tick(1'b0, 1'b0, q);
    repeat (4) @(negedge core_clk);
    chk_pin(pad_out, core_out);
    ctrl.scan(1'b0, 32, '0, d);
    chk_scan(d[31:0], tap_pkg::IDCODE_VAL);
  endtask
  task automatic t_user();
    @(negedge core_clk);
    jtag_en = 1'b0;
    user_out = 1'b1;
    user_oe = 1'b1;
    ctrl.park(1'b0, 1'b1);
    repeat (4) @(negedge core_clk);
    chk_pin(user_in, 3'b100);
    chk_pin(tdo, 1'b1);
    chk_pin(tdo_oe, 1'b1);
    user_out = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_pin(tdo, 1'b0);
    jtag_en = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_pin(user_in, 3'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    jtag_en = 1'b1;
    user_out = 1'b0;
    user_oe = 1'b0;
    pin_in = {8'h3C, 64'h0123_4567_89AB_CDEF};
    core_out = 68'hF_0F0F_1234_5678_9ABC;
    core_oe = 68'h5_AAAA_FFFF_0000_C3C3;
    mc_q = 64'h1357_9BDF_2468_ACE0;
    pre = {35{8'h6B}};
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_idcode();
    t_bypass(tap_pkg::OP_BYPASS);
    repeat (4) @(negedge core_clk);
    chk_pin(pad_out, core_out);
    chk_pin(pad_oe, core_oe);
    t_sample();
    t_extest();
    t_rerst();
    t_bypass(tap_pkg::OP_HIGHZ);
    chk_pin(pad_oe, 72'h0);
    t_user();
    t_idcode();
    tally_and_finish();
  end
endmodule
`default_nettype wire
